// ---- include/vmon_pkg.sv ----
package vmon_pkg;
  localparam int NR = 2;
  localparam int MV_W = 16;
  localparam int ARM_W = 20;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PREBIAS_ARM_NS = 350000;
  localparam int FIXED_ARM_NS = 20000000;
  localparam int PREBIAS_TRIP_MV = 3700;
  localparam int FIX_BASE_MV = 600;
  localparam int FIX_STEP_MV = 100;
  localparam int FIX_MAX_MV = 3700;
  localparam int FIX_CODE_W = 5;
  localparam int SCALE_ONE = 256;
  localparam int UV_PER_MV = 1000;
  localparam int F_STEP_MV = 32;
  localparam int F_MIN_CODE = 1;
  localparam int F_MAX_CODE = 14;
  localparam int W_STEP_MV = 8;
  localparam int W_MIN_CODE = 3;
  localparam int W_MAX_CODE = 56;
  localparam int F_W = 4;
  localparam int W_W = 6;
  localparam logic [F_W-1:0] OVF_RST = 4'h8;
  localparam logic [W_W-1:0] OVW_RST = 6'h10;
  localparam logic [F_W-1:0] UVF_RST = 4'h8;
  localparam logic [W_W-1:0] UVW_RST = 6'h10;
  localparam int ST_W = 4;
  localparam int ST_UVW = 0;
  localparam int ST_UVF = 1;
  localparam int ST_OVW = 2;
  localparam int ST_OVF = 3;
  typedef enum logic [1:0] {
    LIM_OVF = 2'b00,
    LIM_OVW = 2'b01,
    LIM_UVF = 2'b10,
    LIM_UVW = 2'b11
  } lim_kind_type;
  typedef struct packed {
    logic [ARM_W-1:0] arm_cnt;
    logic prebias_flt;
    logic [NR-1:0] cat_flt;
    logic [NR-1:0][F_W-1:0] ofs_ovf;
    logic [NR-1:0][W_W-1:0] ofs_ovw;
    logic [NR-1:0][F_W-1:0] ofs_uvf;
    logic [NR-1:0][W_W-1:0] ofs_uvw;
    logic [NR-1:0][ST_W-1:0] vstat;
    logic [NR-1:0] pwm_low;
    logic [NR-1:0] pwm_tri;
    logic [NR-1:0] rdy;
    logic [MV_W-1:0] lim_rd;
    logic alert_n;
    logic fault_n;
  } mon_state_type;
endpackage

// ---- hw/output_voltage_fault_monitor.sv ----
// Summary of operation
// - Pre-bias trip armed by 350 us after power-up until init done.
// - Pre-bias trip level is a fixed 3.7 V, not programmable.
// - Pre-bias trip pulls every PWM low on both rails, any setting.
// - Pre-bias fault stays latched; only a power cycle releases it.
// - Fixed trip active by 20 ms after power-up, never disabled.
// - Fixed trip compares positive sense pin at all times.
// - Fixed trip while not converting latches until power cycle.
// - Fixed trip level 0.6 V to 3.7 V in 100 mV steps.
// - Tracking OV fault only while converting, sense above threshold.
// - Tracking OV warning while converting; never stops conversion.
// - OV warning sets status bits and alert unless masked.
// - Unignored OV fault pulls rail PWM low, sets status, alerts.
// - OV fault limit write stores (limit-cmd)/scale, 32..448 mV by 32.
// - OV warning limit write stores offset, 24..448 mV by 8.
// - OV trip levels add offset, UV levels subtract it; all subtract droop; OV fault capped by fixed.
// - Command change keeps offsets; limit read is command plus OV offset or minus UV offset.
// - Tracking UV fault while converting, sense below threshold.
// - Tracking UV warning while converting, sense below threshold.
// - UV warning sets status bits and alert unless masked.
// - Unignored UV fault tristates rail PWM, sets status, alerts.
// - UV fault limit write stores (cmd-limit)/scale, 32..448 mV by 32.
// - UV warning limit write stores offset, 24..448 mV by 8.
// - Shutdown drops ready; every fault except pre-bias has maskable status and alert.
module output_voltage_fault_monitor
  import vmon_pkg::*;
#(
  parameter int PREBIAS_ARM_CYC = PREBIAS_ARM_NS / CLK_PERIOD_NS,
  parameter int FIXED_ARM_CYC = FIXED_ARM_NS / CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic init_done,
  input wire logic clear_faults,
  input wire logic [NR-1:0] conv_on,
  input wire logic [NR-1:0][MV_W-1:0] sense_positive_pin,
  input wire logic [NR-1:0][MV_W-1:0] sense_diff_mv,
  input wire logic [NR-1:0][MV_W-1:0] vout_command_mv,
  input wire logic [NR-1:0][MV_W-1:0] scale_loop_q8,
  input wire logic [NR-1:0][MV_W-1:0] droop_uohm,
  input wire logic [NR-1:0][MV_W-1:0] iout_amp,
  input wire logic [NR-1:0][FIX_CODE_W-1:0] vendor_protection_setup,
  input wire logic [NR-1:0] ov_resp_ignore,
  input wire logic [NR-1:0] uv_resp_ignore,
  input wire logic [NR-1:0][ST_W-1:0] status_mask,
  input wire logic limit_wr,
  input wire logic limit_rail,
  input wire lim_kind_type limit_kind,
  input wire logic [MV_W-1:0] limit_mv,
  input wire logic rd_rail,
  input wire lim_kind_type rd_kind,
  output logic [NR-1:0] pwm_low,
  output logic [NR-1:0] pwm_tristate,
  output logic [NR-1:0][ST_W-1:0] vout_status,
  output logic [NR-1:0] regulator_ready_out,
  output logic regulator_fault_out_n,
  output logic smbalert_n,
  output logic prebias_fault,
  output logic [NR-1:0] fixed_trip_latched,
  output logic [MV_W-1:0] limit_rd_mv
);

  mon_state_type st_r;
  mon_state_type st_nxt;

  logic prebias_armed;
  logic fixed_armed;
  logic prebias_hit;
  logic [NR-1:0] pb_over;
  logic [NR-1:0] fix_hit;
  logic [NR-1:0] ovf_hit;
  logic [NR-1:0] ovw_hit;
  logic [NR-1:0] uvf_hit;
  logic [NR-1:0] uvw_hit;
  logic [NR-1:0] running;
  int droop_mv [NR];
  int fix_mv [NR];
  int ovf_trk [NR];
  int ovf_lvl [NR];
  int ovw_lvl [NR];
  int uvf_lvl [NR];
  int uvw_lvl [NR];

  // Offset code rounded to nearest step, clamped
  // A zero scale counts as one lsb so the divide never faults
  function automatic int ofs_code(input int diff, input int scale,
                                  input int step, input int cmin,
                                  input int cmax);
    int den;
    int q;
    den = ((scale == 0) ? 1 : scale) * step;
    if (diff <= 0) begin
      q = cmin;
    end else begin
      q = (diff * SCALE_ONE + den / 2) / den;
    end
    if (q < cmin) begin
      q = cmin;
    end else if (q > cmax) begin
      q = cmax;
    end
    return q;
  endfunction

  assign prebias_armed = (int'(st_r.arm_cnt) >= PREBIAS_ARM_CYC)
                         && !init_done;
  assign fixed_armed = int'(st_r.arm_cnt) >= FIXED_ARM_CYC;
  assign prebias_hit = prebias_armed && (|pb_over);

  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_rail
      assign pb_over[g] = int'(sense_positive_pin[g]) > PREBIAS_TRIP_MV;
      // Droop in uV scaled to mV; uohm times amps gives uV
      assign droop_mv[g] = (int'(droop_uohm[g]) * int'(iout_amp[g]))
                           / UV_PER_MV;
      assign fix_mv[g] =
        (FIX_BASE_MV + int'(vendor_protection_setup[g]) * FIX_STEP_MV
         > FIX_MAX_MV) ? FIX_MAX_MV :
        FIX_BASE_MV + int'(vendor_protection_setup[g]) * FIX_STEP_MV;
      assign ovf_trk[g] = int'(vout_command_mv[g])
                          + int'(st_r.ofs_ovf[g]) * F_STEP_MV
                          - droop_mv[g];
      assign ovf_lvl[g] = (fix_mv[g] < ovf_trk[g]) ? fix_mv[g]
                                                     : ovf_trk[g];
      assign ovw_lvl[g] = int'(vout_command_mv[g])
                          + int'(st_r.ofs_ovw[g]) * W_STEP_MV
                          - droop_mv[g];
      assign uvf_lvl[g] = int'(vout_command_mv[g])
                          - int'(st_r.ofs_uvf[g]) * F_STEP_MV
                          - droop_mv[g];
      assign uvw_lvl[g] = int'(vout_command_mv[g])
                          - int'(st_r.ofs_uvw[g]) * W_STEP_MV
                          - droop_mv[g];
      // Tracking detection stops once the rail is shut down
      assign running[g] = conv_on[g] && !st_r.pwm_low[g]
                          && !st_r.pwm_tri[g];
      assign fix_hit[g] = fixed_armed
                          && int'(sense_positive_pin[g]) > fix_mv[g];
      assign ovf_hit[g] = running[g]
                          && int'(sense_diff_mv[g]) > ovf_lvl[g];
      assign ovw_hit[g] = running[g]
                          && int'(sense_diff_mv[g]) > ovw_lvl[g];
      assign uvf_hit[g] = running[g]
                          && int'(sense_diff_mv[g]) < uvf_lvl[g];
      assign uvw_hit[g] = running[g]
                          && int'(sense_diff_mv[g]) < uvw_lvl[g];
    end
  endgenerate

  always_comb begin
    int rs;
    int rk;
    int cmd;
    int off;
    rs = int'(rd_rail);
    rk = int'(limit_rail);
    cmd = 0;
    off = 0;
    st_nxt = st_r;
    // Counter saturates so the arm compares never wrap
    if (int'(st_r.arm_cnt) < FIXED_ARM_CYC) begin
      st_nxt.arm_cnt = st_r.arm_cnt + ARM_W'(1);
    end
    if (prebias_hit) begin
      st_nxt.prebias_flt = 1'b1;
    end
    for (int i = 0; i < NR; i++) begin
      if (clear_faults) begin
        st_nxt.vstat[i] = '0;
        st_nxt.pwm_low[i] = 1'b0;
        st_nxt.pwm_tri[i] = 1'b0;
      end
      // OV warning status, set wins over clear
      if (ovw_hit[i]) begin
        st_nxt.vstat[i][ST_OVW] = 1'b1;
      end
      if (uvw_hit[i]) begin
        st_nxt.vstat[i][ST_UVW] = 1'b1;
      end
      if (ovf_hit[i]) begin
        st_nxt.vstat[i][ST_OVF] = 1'b1;
      end
      if (uvf_hit[i]) begin
        st_nxt.vstat[i][ST_UVF] = 1'b1;
      end
      if (ovf_hit[i] && !ov_resp_ignore[i]) begin
        st_nxt.pwm_low[i] = 1'b1;
      end
      if (uvf_hit[i] && !uv_resp_ignore[i]) begin
        st_nxt.pwm_tri[i] = 1'b1;
      end
      if (fix_hit[i] && !conv_on[i]) begin
        st_nxt.cat_flt[i] = 1'b1;
        st_nxt.vstat[i][ST_OVF] = 1'b1;
      end
      if (st_nxt.cat_flt[i]) begin
        st_nxt.pwm_low[i] = 1'b1;
      end
      if (st_nxt.prebias_flt) begin
        st_nxt.pwm_low[i] = 1'b1;
      end
      // Low drive wins over tristate on the same rail
      if (st_nxt.pwm_low[i]) begin
        st_nxt.pwm_tri[i] = 1'b0;
      end
      st_nxt.rdy[i] = conv_on[i] && !st_nxt.pwm_low[i]
                      && !st_nxt.pwm_tri[i];
    end
    if (limit_wr) begin
      cmd = int'(vout_command_mv[rk]);
      if (limit_kind == LIM_OVF) begin
        st_nxt.ofs_ovf[rk] = F_W'(ofs_code(int'(limit_mv) - cmd,
          int'(scale_loop_q8[rk]), F_STEP_MV, F_MIN_CODE, F_MAX_CODE));
      end else if (limit_kind == LIM_OVW) begin
        st_nxt.ofs_ovw[rk] = W_W'(ofs_code(int'(limit_mv) - cmd,
          int'(scale_loop_q8[rk]), W_STEP_MV, W_MIN_CODE, W_MAX_CODE));
      end else if (limit_kind == LIM_UVF) begin
        st_nxt.ofs_uvf[rk] = F_W'(ofs_code(cmd - int'(limit_mv),
          int'(scale_loop_q8[rk]), F_STEP_MV, F_MIN_CODE, F_MAX_CODE));
      end else begin
        st_nxt.ofs_uvw[rk] = W_W'(ofs_code(cmd - int'(limit_mv),
          int'(scale_loop_q8[rk]), W_STEP_MV, W_MIN_CODE, W_MAX_CODE));
      end
    end
    // Limitation: readback is not rescaled by the loop scale factor
    // Read back uses present command
    case (rd_kind)
      LIM_OVF: begin
        off = int'(st_r.ofs_ovf[rs]) * F_STEP_MV;
      end
      LIM_OVW: begin
        off = int'(st_r.ofs_ovw[rs]) * W_STEP_MV;
      end
      LIM_UVF: begin
        off = -int'(st_r.ofs_uvf[rs]) * F_STEP_MV;
      end
      default: begin
        off = -int'(st_r.ofs_uvw[rs]) * W_STEP_MV;
      end
    endcase
    st_nxt.lim_rd = MV_W'(int'(vout_command_mv[rs]) + off);
    st_nxt.alert_n = 1'b1;
    for (int i = 0; i < NR; i++) begin
      if (|(st_nxt.vstat[i] & ~status_mask[i])) begin
        st_nxt.alert_n = 1'b0;
      end
    end
    st_nxt.fault_n = !(|(st_nxt.pwm_low | st_nxt.pwm_tri));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
      // Offsets come up at defaults (fault code 8, warning code 16), not at zero
      st_r.ofs_ovf <= {NR{OVF_RST}};
      st_r.ofs_ovw <= {NR{OVW_RST}};
      st_r.ofs_uvf <= {NR{UVF_RST}};
      st_r.ofs_uvw <= {NR{UVW_RST}};
      st_r.alert_n <= 1'b1;
      st_r.fault_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm_low = st_r.pwm_low;
  assign pwm_tristate = st_r.pwm_tri;
  assign vout_status = st_r.vstat;
  assign regulator_ready_out = st_r.rdy;
  assign regulator_fault_out_n = st_r.fault_n;
  assign smbalert_n = st_r.alert_n;
  assign prebias_fault = st_r.prebias_flt;
  assign fixed_trip_latched = st_r.cat_flt;
  assign limit_rd_mv = st_r.lim_rd;

endmodule

// ---- verification/rail_stage.sv ----
module rail_stage
  import vmon_pkg::*;
(
  input wire logic [NR-1:0][MV_W-1:0] level_mv,
  output logic [NR-1:0][MV_W-1:0] sense_positive_pin,
  output logic [NR-1:0][MV_W-1:0] sense_diff_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Return line held at ground, so both pins show the rail level
  assign sense_positive_pin = level_mv;
  assign sense_diff_mv = level_mv;
endmodule

// ---- verification/vmon_monitor.sv ----
module vmon_monitor
  import vmon_pkg::*;
#(
  parameter int PREBIAS_ARM_CYC = 10,
  parameter int FIXED_ARM_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic init_done,
  input wire logic [NR-1:0] conv_on,
  input wire logic [NR-1:0][MV_W-1:0] sense_positive_pin,
  input wire logic [NR-1:0][FIX_CODE_W-1:0] vendor_protection_setup,
  input wire logic [NR-1:0] ov_resp_ignore,
  input wire logic [NR-1:0] uv_resp_ignore,
  input wire logic [NR-1:0][ST_W-1:0] status_mask,
  input wire logic [NR-1:0] pwm_low,
  input wire logic [NR-1:0] pwm_tristate,
  input wire logic [NR-1:0][ST_W-1:0] vout_status,
  input wire logic [NR-1:0] regulator_ready_out,
  input wire logic regulator_fault_out_n,
  input wire logic smbalert_n,
  input wire logic prebias_fault,
  input wire logic [NR-1:0] fixed_trip_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] age_r;
  logic [15:0] age_nxt;
  int fix_mv;
  // Margin of two cycles over the arm count covers its start edge
  always_comb begin
    age_nxt = (age_r == 16'hFFFF) ? age_r : age_r + 16'h1;
    fix_mv = FIX_BASE_MV + FIX_STEP_MV * int'(vendor_protection_setup[0]);
    if (fix_mv > FIX_MAX_MV) fix_mv = FIX_MAX_MV;
  end
  always_ff @(posedge clk_sys) begin
    age_r <= sys_rst ? 16'h0 : age_nxt;
  end
  a_prebias_trip: assert property (
    age_r > PREBIAS_ARM_CYC + 2 && !init_done
    && int'(sense_positive_pin[0]) > PREBIAS_TRIP_MV |=> prebias_fault)
    else $error("pre-bias trip missed");
  a_prebias_all_low: assert property (
    prebias_fault |-> pwm_low == 2'h3)
    else $error("pre-bias trip left a PWM free");
  a_prebias_held: assert property (
    prebias_fault |=> prebias_fault)
    else $error("pre-bias latch released");
  a_fixed_trip: assert property (
    age_r > FIXED_ARM_CYC + 2 && !conv_on[0]
    && int'(sense_positive_pin[0]) > fix_mv |=> fixed_trip_latched[0])
    else $error("fixed trip missed");
  a_fixed_held: assert property (
    fixed_trip_latched[0] |=> fixed_trip_latched[0])
    else $error("fixed trip latch released");
  a_ovf_pulls_low: assert property (
    $rose(vout_status[0][ST_OVF]) && !$past(ov_resp_ignore[0])
    |-> pwm_low[0])
    else $error("over-voltage fault left PWM running");
  a_uvf_tristates: assert property (
    $rose(vout_status[0][ST_UVF]) && !$past(uv_resp_ignore[0])
    |-> pwm_tristate[0])
    else $error("under-voltage fault left PWM running");
  a_pwm_exclusive: assert property (
    (pwm_low & pwm_tristate) == 2'h0)
    else $error("PWM low and tristate together");
  a_ready_drops: assert property (
    pwm_low[0] || pwm_tristate[0] |-> !regulator_ready_out[0])
    else $error("ready kept during shutdown");
  a_fault_pin: assert property (
    (pwm_low | pwm_tristate) != 2'h0 && !prebias_fault
    |-> !regulator_fault_out_n)
    else $error("fault pin idle during shutdown");
  a_alert_unmasked: assert property (
    ((vout_status[0] & ~status_mask[0]) != 4'h0
    && $stable(status_mask))[*2] |-> !smbalert_n)
    else $error("alert missing for unmasked status");
endmodule

// ---- verification/output_voltage_fault_monitor_test.sv ----
module output_voltage_fault_monitor_test
  import vmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic init_done = 1'h0;
  logic clear_faults = 1'h0;
  logic limit_wr = 1'h0;
  logic limit_rail = 1'h0;
  logic rd_rail = 1'h0;
  logic [NR-1:0] conv_on = 2'h0;
  logic [NR-1:0] ov_resp_ignore = 2'h0;
  logic [NR-1:0] uv_resp_ignore = 2'h0;
  logic [NR-1:0][MV_W-1:0] level_mv = {2{16'h3E8}};
  logic [NR-1:0][MV_W-1:0] vout_command_mv = {2{16'h3E8}};
  logic [NR-1:0][MV_W-1:0] scale_loop_q8 = {2{16'h100}};
  logic [NR-1:0][MV_W-1:0] droop_uohm = {16'h0, 16'h1F4};
  logic [NR-1:0][MV_W-1:0] iout_amp = {2{16'h64}};
  logic [NR-1:0][FIX_CODE_W-1:0] vendor_protection_setup = {2{5'h1F}};
  logic [NR-1:0][ST_W-1:0] status_mask = '0;
  lim_kind_type limit_kind = LIM_OVF;
  lim_kind_type rd_kind = LIM_OVF;
  logic [MV_W-1:0] limit_mv = 16'h0;
  logic [NR-1:0][MV_W-1:0] sense_positive_pin;
  logic [NR-1:0][MV_W-1:0] sense_diff_mv;
  logic [NR-1:0] pwm_low;
  logic [NR-1:0] pwm_tristate;
  logic [NR-1:0][ST_W-1:0] vout_status;
  logic [NR-1:0] regulator_ready_out;
  logic regulator_fault_out_n;
  logic smbalert_n;
  logic prebias_fault;
  logic [NR-1:0] fixed_trip_latched;
  logic [MV_W-1:0] limit_rd_mv;
  // Limits at 1000 mV, then readback once the command is 1100 mV
  logic [15:0] lim_a [4] = '{16'h4E8, 16'h468, 16'h2E8, 16'h368};
  logic [15:0] lim_b [4] = '{16'h54C, 16'h4CC, 16'h34C, 16'h3CC};
  int error_cnt = 0;
  int checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  rail_stage i_rail_stage (
    .level_mv(level_mv),
    .sense_positive_pin(sense_positive_pin),
    .sense_diff_mv(sense_diff_mv)
  );
  // Short arm counts keep the power-up walk brief
  output_voltage_fault_monitor #(.PREBIAS_ARM_CYC(10), .FIXED_ARM_CYC(20))
    i_output_voltage_fault_monitor (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .init_done(init_done),
    .clear_faults(clear_faults),
    .conv_on(conv_on),
    .sense_positive_pin(sense_positive_pin),
    .sense_diff_mv(sense_diff_mv),
    .vout_command_mv(vout_command_mv),
    .scale_loop_q8(scale_loop_q8),
    .droop_uohm(droop_uohm),
    .iout_amp(iout_amp),
    .vendor_protection_setup(vendor_protection_setup),
    .ov_resp_ignore(ov_resp_ignore),
    .uv_resp_ignore(uv_resp_ignore),
    .status_mask(status_mask),
    .limit_wr(limit_wr),
    .limit_rail(limit_rail),
    .limit_kind(limit_kind),
    .limit_mv(limit_mv),
    .rd_rail(rd_rail),
    .rd_kind(rd_kind),
    .pwm_low(pwm_low),
    .pwm_tristate(pwm_tristate),
    .vout_status(vout_status),
    .regulator_ready_out(regulator_ready_out),
    .regulator_fault_out_n(regulator_fault_out_n),
    .smbalert_n(smbalert_n),
    .prebias_fault(prebias_fault),
    .fixed_trip_latched(fixed_trip_latched),
    .limit_rd_mv(limit_rd_mv)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rd(input logic r, input lim_kind_type k);
    @(posedge clk_sys);
    rd_rail <= r;
    rd_kind <= k;
    tick(3);
  endtask
  task automatic wr(input logic r, input lim_kind_type k,
                    input logic [15:0] v);
    @(posedge clk_sys);
    limit_wr <= 1'h1;
    limit_rail <= r;
    limit_kind <= k;
    limit_mv <= v;
    @(posedge clk_sys);
    limit_wr <= 1'h0;
    rd(r, k);
  endtask
  task automatic drv(input logic [15:0] v);
    @(posedge clk_sys);
    level_mv[0] <= v;
    tick(2);
  endtask
  task automatic clr;
    @(posedge clk_sys);
    level_mv[0] <= 16'h3E8;
    clear_faults <= 1'h1;
    @(posedge clk_sys);
    clear_faults <= 1'h0;
    tick(2);
  endtask
  initial begin
    int n;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    level_mv[0] <= 16'hE74;
    tick(15);
    chk(prebias_fault, 1'h0);
    @(posedge clk_sys);
    level_mv[0] <= 16'hE75;
    for (n = 0; n < 20 && prebias_fault !== 1'h1; n++) tick(1);
    if (n == 20) begin
      error_cnt++;
      stop_test();
    end
    chk(pwm_low, 2'h3);
    clr();
    chk(prebias_fault, 1'h1);
    chk(pwm_low, 2'h3);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    init_done <= 1'h1;
    tick(1);
    chk(prebias_fault, 1'h0);
    for (int k = 0; k < 4; k++) begin
      wr(1'h0, lim_kind_type'(k), lim_a[k]);
      chk(limit_rd_mv, lim_a[k]);
    end
    @(posedge clk_sys);
    vout_command_mv[0] <= 16'h44C;
    for (int k = 0; k < 4; k++) begin
      rd(1'h0, lim_kind_type'(k));
      chk(limit_rd_mv, lim_b[k]);
    end
    @(posedge clk_sys);
    vout_command_mv[0] <= 16'h3E8;
    wr(1'h1, LIM_OVF, 16'h5DC);
    chk(limit_rd_mv, 16'h5A8);
    wr(1'h1, LIM_OVW, 16'h3F2);
    chk(limit_rd_mv, 16'h400);
    @(posedge clk_sys);
    scale_loop_q8[1] <= 16'h80;
    wr(1'h1, LIM_OVF, 16'h468);
    chk(limit_rd_mv, 16'h4E8);
    drv(16'h4BA);
    chk(vout_status[0], 4'h0);
    // Rail back in window before conversion starts, else it trips at once
    drv(16'h3E8);
    @(posedge clk_sys);
    conv_on <= 2'h3;
    tick(2);
    chk(regulator_ready_out[0], 1'h1);
    drv(16'h4B0);
    chk(vout_status[0], 4'h4);
    chk(pwm_low[0], 1'h0);
    chk(smbalert_n, 1'h0);
    drv(16'h4BA);
    chk(vout_status[0], 4'hC);
    chk(pwm_low[0], 1'h1);
    chk(regulator_ready_out[0], 1'h0);
    chk(regulator_fault_out_n, 1'h0);
    clr();
    chk(vout_status[0], 4'h0);
    drv(16'h320);
    chk(vout_status[0], 4'h1);
    drv(16'h2B2);
    chk(vout_status[0], 4'h3);
    chk(pwm_tristate[0], 1'h1);
    chk(pwm_low[0], 1'h0);
    clr();
    @(posedge clk_sys);
    status_mask[0] <= 4'hF;
    ov_resp_ignore <= 2'h3;
    uv_resp_ignore <= 2'h3;
    drv(16'h4BA);
    chk(vout_status[0], 4'hC);
    chk(pwm_low[0], 1'h0);
    chk(smbalert_n, 1'h1);
    drv(16'h2B2);
    chk(pwm_tristate[0], 1'h0);
    clr();
    // Level and fixed code move together so no stale level trips
    @(posedge clk_sys);
    conv_on <= 2'h0;
    status_mask[0] <= 4'h0;
    vendor_protection_setup[0] <= 5'h1;
    level_mv[0] <= 16'h2BC;
    tick(2);
    chk(fixed_trip_latched[0], 1'h0);
    @(posedge clk_sys);
    vendor_protection_setup[0] <= 5'h0;
    tick(2);
    chk(fixed_trip_latched[0], 1'h1);
    chk(pwm_low[0], 1'h1);
    clr();
    chk(fixed_trip_latched[0], 1'h1);
    stop_test();
  end
endmodule
bind output_voltage_fault_monitor vmon_monitor #(
  .PREBIAS_ARM_CYC(PREBIAS_ARM_CYC),
  .FIXED_ARM_CYC(FIXED_ARM_CYC)
) i_vmon_monitor (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .init_done(init_done),
  .conv_on(conv_on),
  .sense_positive_pin(sense_positive_pin),
  .vendor_protection_setup(vendor_protection_setup),
  .ov_resp_ignore(ov_resp_ignore),
  .uv_resp_ignore(uv_resp_ignore),
  .status_mask(status_mask),
  .pwm_low(pwm_low),
  .pwm_tristate(pwm_tristate),
  .vout_status(vout_status),
  .regulator_ready_out(regulator_ready_out),
  .regulator_fault_out_n(regulator_fault_out_n),
  .smbalert_n(smbalert_n),
  .prebias_fault(prebias_fault),
  .fixed_trip_latched(fixed_trip_latched)
);
